/* hw/slave_access_unit.sv */
// Register access unit: validates slave register read/write requests and runs them on the ring.
`timescale 1ns/10ps
// How it works
// RULE1 - read start zeroes data and count
// RULE2 - read codes 1,4,7 else error 0x0F62
// RULE3 - write codes 2,5,8 else error 0x0F72
// RULE4 - length 1..4 else 0x0F61/0x0F71
// RULE5 - bad read address gives 0x0F60, broadcast ignores
// RULE6 - bad write address gives 0x0F70, broadcast ignores
// RULE7 - slaves increment position, zero one accesses
// RULE8 - position range 0x0000 then 0xFFFF..0xFFDD
// RULE9 - configured slave matches its station address
// RULE10 - station addresses 1001..1036 only
// RULE11 - broadcast read ORs every slave's data
// RULE12 - working count adds one per reader
// RULE13 - broadcast write counts every writer
// RULE14 - write start zeroes count, completion presents it
// RULE15 - done after normal read by slave
// RULE16 - done after normal write by slave
// RULE17 - link check: broadcast read offset 0x0130
// RULE18 - start on rising edge, one at once
// RULE19 - validation error: flag, no access, no done
module slave_access_unit (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  output logic             irq_o,
  ring_link_if.unit        link
);

  typedef enum logic [0:0] {IDLE, XFER} unit_state_e;

  typedef struct packed {
    unit_state_e st;
    logic        start;
    logic        sw_write;
    logic [3:0]  sw_cmd;
    logic [2:0]  sw_len;
    logic [15:0] sw_adp;
    logic [15:0] sw_ado;
    logic [31:0] sw_wdata;
    logic        l_req;
    logic        l_write;
    logic [3:0]  l_cmd;
    logic [2:0]  l_len;
    logic [15:0] l_adp;
    logic [15:0] l_ado;
    logic [31:0] l_wdata;
    logic [31:0] rdata;
    logic [15:0] wkc;
    logic        busy;
    logic        done;
    logic        err;
    logic        noresp;
    logic [15:0] err_code;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } unit_s;

  unit_s cur_ff;
  unit_s nxt_cur;

  // ==========================================================================
  // Request validation
  function automatic logic [15:0] check_req(input logic wr, input logic [3:0] cmd,
                                            input logic [2:0] len, input logic [15:0] adp);
    logic        auto_ok;
    logic        cfg_ok;
    logic [15:0] code;
    auto_ok = (adp == fieldbus_pkg::AUTO_FIRST) || (adp >= fieldbus_pkg::AUTO_LAST); // [RULE8]
    cfg_ok  = (adp >= fieldbus_pkg::CFG_FIRST) && (adp <= fieldbus_pkg::CFG_LAST);   // [RULE10]
    code    = fieldbus_pkg::ERR_NONE;
    if (!wr)
    begin
      if (cmd != fieldbus_pkg::CMD_AUTO_RD && cmd != fieldbus_pkg::CMD_CFG_RD &&
          cmd != fieldbus_pkg::CMD_BCAST_RD)
        code = fieldbus_pkg::ERR_RD_CMD; // [RULE2]
      else if (len < fieldbus_pkg::LEN_MIN || len > fieldbus_pkg::LEN_MAX)
        code = fieldbus_pkg::ERR_RD_LEN; // [RULE4]
      else if ((cmd == fieldbus_pkg::CMD_AUTO_RD && !auto_ok) ||
               (cmd == fieldbus_pkg::CMD_CFG_RD && !cfg_ok))
        code = fieldbus_pkg::ERR_RD_ADDR; // [RULE5]
    end
    else
    begin
      if (cmd != fieldbus_pkg::CMD_AUTO_WR && cmd != fieldbus_pkg::CMD_CFG_WR &&
          cmd != fieldbus_pkg::CMD_BCAST_WR)
        code = fieldbus_pkg::ERR_WR_CMD; // [RULE3]
      else if (len < fieldbus_pkg::LEN_MIN || len > fieldbus_pkg::LEN_MAX)
        code = fieldbus_pkg::ERR_WR_LEN; // [RULE4]
      else if ((cmd == fieldbus_pkg::CMD_AUTO_WR && !auto_ok) ||
               (cmd == fieldbus_pkg::CMD_CFG_WR && !cfg_ok))
        code = fieldbus_pkg::ERR_WR_ADDR; // [RULE6]
    end
    return code;
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic        acc;
    logic        wr_now;
    logic        mapped;
    logic [31:0] rd_val;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic        new_start;
    logic [15:0] code;
    acc       = psel_i && penable_i;
    wr_now    = acc && cur_ff.pready && pwrite_i;
    mapped    = 1'b1;
    rd_val    = 32'h0000_0000;
    irq_set   = 3'h0;
    irq_clr   = 3'h0;
    new_start = 1'b0;
    code      = fieldbus_pkg::ERR_NONE;
    nxt_cur   = cur_ff;

    case (paddr_i)
      fieldbus_pkg::REG_CTRL:
      begin
        rd_val[fieldbus_pkg::CTRL_START] = cur_ff.start;
        rd_val[fieldbus_pkg::CTRL_WRITE] = cur_ff.sw_write;
      end
      fieldbus_pkg::REG_CMD:
      begin
        rd_val[fieldbus_pkg::CMD_LSB +: 4] = cur_ff.sw_cmd;
        rd_val[fieldbus_pkg::LEN_LSB +: 3] = cur_ff.sw_len;
      end
      fieldbus_pkg::REG_ADDR:     rd_val = {cur_ff.sw_ado, cur_ff.sw_adp};
      fieldbus_pkg::REG_WDATA:    rd_val = cur_ff.sw_wdata;
      fieldbus_pkg::REG_RDATA:    rd_val = cur_ff.rdata;
      fieldbus_pkg::REG_STATUS:
      begin
        rd_val[fieldbus_pkg::ST_BUSY]       = cur_ff.busy;
        rd_val[fieldbus_pkg::ST_DONE]       = cur_ff.done;
        rd_val[fieldbus_pkg::ST_ERR]        = cur_ff.err;
        rd_val[fieldbus_pkg::ST_NORESP]     = cur_ff.noresp;
        rd_val[fieldbus_pkg::ST_CODE +: 16] = cur_ff.err_code;
      end
      fieldbus_pkg::REG_WKC:      rd_val[15:0] = cur_ff.wkc;
      fieldbus_pkg::REG_IRQ_STAT: rd_val[fieldbus_pkg::IRQ_W-1:0] = cur_ff.irq_stat;
      fieldbus_pkg::REG_IRQ_CLR:  rd_val = 32'h0000_0000;
      fieldbus_pkg::REG_IRQ_EN:   rd_val[fieldbus_pkg::IRQ_W-1:0] = cur_ff.irq_en;
      default:                    mapped = 1'b0;
    endcase

    // One wait state: the answer is computed in the first access cycle and registered.
    if (acc && !cur_ff.pready)
    begin
      nxt_cur.pready  = 1'b1;
      nxt_cur.pslverr = !mapped;
      nxt_cur.prdata  = (pwrite_i || !mapped) ? 32'h0000_0000 : rd_val;
    end
    else
    begin
      nxt_cur.pready  = 1'b0;
      nxt_cur.pslverr = 1'b0;
    end

    if (wr_now && mapped)
    begin
      case (paddr_i)
        fieldbus_pkg::REG_CTRL:
        begin
          nxt_cur.start    = pwdata_i[fieldbus_pkg::CTRL_START];
          nxt_cur.sw_write = pwdata_i[fieldbus_pkg::CTRL_WRITE];
          new_start        = pwdata_i[fieldbus_pkg::CTRL_START] && !cur_ff.start; // [RULE18]
        end
        fieldbus_pkg::REG_CMD:
        begin
          nxt_cur.sw_cmd = pwdata_i[fieldbus_pkg::CMD_LSB +: 4];
          nxt_cur.sw_len = pwdata_i[fieldbus_pkg::LEN_LSB +: 3];
        end
        fieldbus_pkg::REG_ADDR:
        begin
          nxt_cur.sw_adp = pwdata_i[fieldbus_pkg::ADP_LSB +: 16];
          nxt_cur.sw_ado = pwdata_i[fieldbus_pkg::ADO_LSB +: 16];
        end
        fieldbus_pkg::REG_WDATA:   nxt_cur.sw_wdata = pwdata_i;
        fieldbus_pkg::REG_IRQ_CLR: irq_clr = pwdata_i[fieldbus_pkg::IRQ_W-1:0];
        fieldbus_pkg::REG_IRQ_EN:  nxt_cur.irq_en = pwdata_i[fieldbus_pkg::IRQ_W-1:0];
        default:                   nxt_cur.irq_en = cur_ff.irq_en;
      endcase
    end

    case (cur_ff.st)
      IDLE:
      begin
        // The mode bit written together with the start edge is the one that counts.
        if (new_start) // [RULE18]
        begin
          code             = check_req(nxt_cur.sw_write, cur_ff.sw_cmd, cur_ff.sw_len, cur_ff.sw_adp);
          nxt_cur.done     = 1'b0;
          nxt_cur.noresp   = 1'b0;
          nxt_cur.err_code = code;
          nxt_cur.rdata    = 32'h0000_0000; // [RULE1]
          nxt_cur.wkc      = 16'h0000;      // [RULE1] [RULE14]
          if (code != fieldbus_pkg::ERR_NONE)
          begin
            nxt_cur.err = 1'b1; // [RULE19]
            irq_set[fieldbus_pkg::IRQ_ERR] = 1'b1;
          end
          else
          begin
            nxt_cur.err     = 1'b0;
            nxt_cur.busy    = 1'b1;
            nxt_cur.l_req   = 1'b1;
            nxt_cur.l_write = nxt_cur.sw_write;
            nxt_cur.l_cmd   = cur_ff.sw_cmd;
            nxt_cur.l_len   = cur_ff.sw_len;
            nxt_cur.l_adp   = cur_ff.sw_adp;
            nxt_cur.l_ado   = cur_ff.sw_ado;
            nxt_cur.l_wdata = cur_ff.sw_wdata;
            nxt_cur.st      = XFER;
          end
        end
      end
      XFER:
      begin
        if (link.ack)
        begin
          nxt_cur.l_req = 1'b0;
          nxt_cur.busy  = 1'b0;
          nxt_cur.wkc   = link.wkc; // [RULE12] [RULE13] [RULE14]
          nxt_cur.rdata = cur_ff.l_write ? 32'h0000_0000 : link.rdata; // [RULE1] [RULE11]
          // Done only when at least one slave really carried out the access.
          if (link.wkc != 16'h0000)
          begin
            nxt_cur.done = 1'b1; // [RULE15] [RULE16]
            irq_set[fieldbus_pkg::IRQ_DONE] = 1'b1;
          end
          else
          begin
            nxt_cur.noresp = 1'b1;
            irq_set[fieldbus_pkg::IRQ_NORESP] = 1'b1;
          end
          nxt_cur.st = IDLE;
        end
      end
      default: nxt_cur.st = IDLE;
    endcase

    // A new event wins over a clear written in the same cycle.
    nxt_cur.irq_stat = (cur_ff.irq_stat & ~irq_clr) | irq_set;
    nxt_cur.irq      = |(nxt_cur.irq_stat & nxt_cur.irq_en);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      cur_ff    <= '0;
      cur_ff.st <= IDLE;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign pready_o   = cur_ff.pready;
  assign pslverr_o  = cur_ff.pslverr;
  assign prdata_o   = cur_ff.prdata;
  assign irq_o      = cur_ff.irq;
  assign link.req   = cur_ff.l_req;
  assign link.write = cur_ff.l_write;
  assign link.cmd   = cur_ff.l_cmd;
  assign link.adp   = cur_ff.l_adp;
  assign link.ado   = cur_ff.l_ado;
  assign link.len   = cur_ff.l_len;
  assign link.wdata = cur_ff.l_wdata;

endmodule

/* hw/fieldbus_pkg.sv */
// Shared constants for the fieldbus slave register access unit and the ring end.
package fieldbus_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [3:0] CMD_AUTO_RD  = 4'h1;
  localparam logic [3:0] CMD_AUTO_WR  = 4'h2;
  localparam logic [3:0] CMD_CFG_RD   = 4'h4;
  localparam logic [3:0] CMD_CFG_WR   = 4'h5;
  localparam logic [3:0] CMD_BCAST_RD = 4'h7;
  localparam logic [3:0] CMD_BCAST_WR = 4'h8;

  // ==========================================================================
  // Error codes
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_RD_ADDR = 16'h0f60;
  localparam logic [15:0] ERR_RD_LEN  = 16'h0f61;
  localparam logic [15:0] ERR_RD_CMD  = 16'h0f62;
  localparam logic [15:0] ERR_WR_ADDR = 16'h0f70;
  localparam logic [15:0] ERR_WR_LEN  = 16'h0f71;
  localparam logic [15:0] ERR_WR_CMD  = 16'h0f72;

  // ==========================================================================
  // Address and length ranges
  localparam logic [2:0]  LEN_MIN     = 3'h1;
  localparam logic [2:0]  LEN_MAX     = 3'h4;
  localparam logic [15:0] AUTO_FIRST  = 16'h0000;
  localparam logic [15:0] AUTO_LAST   = 16'hffdd;
  localparam logic [15:0] CFG_FIRST   = 16'h03e9;
  localparam logic [15:0] CFG_LAST    = 16'h040c;
  localparam logic [5:0]  NUM_SLAVES  = 6'h24;
  localparam int          SLAVE_BYTES = 16;
  localparam int          SLAVE_AW    = 4;

  // ==========================================================================
  // APB register map and fields
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_ADDR     = 8'h08;
  localparam logic [7:0] REG_WDATA    = 8'h0c;
  localparam logic [7:0] REG_RDATA    = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_WKC      = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1c;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h20;
  localparam logic [7:0] REG_IRQ_EN   = 8'h24;

  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CMD_LSB    = 0;
  localparam int LEN_LSB    = 16;
  localparam int ADP_LSB    = 0;
  localparam int ADO_LSB    = 16;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ERR     = 2;
  localparam int ST_NORESP  = 3;
  localparam int ST_CODE    = 16;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_NORESP = 2;
  localparam int IRQ_W      = 3;

endpackage

/* hw/ring_link_if.sv */
// Link between the register access unit and the ring of slave controllers.
`timescale 1ns/10ps
interface ring_link_if;
  logic        req;
  logic        write;
  logic [3:0]  cmd;
  logic [15:0] adp;
  logic [15:0] ado;
  logic [2:0]  len;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic [15:0] wkc;

  modport unit (output req, write, cmd, adp, ado, len, wdata, input ack, rdata, wkc);
  modport ring (input req, write, cmd, adp, ado, len, wdata, output ack, rdata, wkc);
endinterface

/* hw/slave_ring_end.sv */
// Ring end: a chain of slave controllers that each hold a small register space.
`timescale 1ns/10ps
module slave_ring_end (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic [5:0] station_count_i,
  output logic            busy_o,
  ring_link_if.ring       link
);

  typedef enum logic [1:0] {IDLE, WALK, ANSWER} ring_state_e;

  typedef struct packed {
    ring_state_e st;
    logic [5:0]  idx;
    logic [15:0] adp_run;
    logic        write;
    logic [3:0]  cmd;
    logic [2:0]  len;
    logic [15:0] adp;
    logic [3:0]  ado;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [15:0] wkc;
    logic        ack;
    logic        busy;
  } ring_s;

  ring_s       cur_ff;
  ring_s       nxt_cur;
  logic [7:0]  mem [fieldbus_pkg::NUM_SLAVES][fieldbus_pkg::SLAVE_BYTES];
  logic        hit;
  logic        live;

  // ==========================================================================
  // Per-slave addressing
  always_comb
  begin
    live = (cur_ff.st == WALK) && (cur_ff.idx < station_count_i) && (cur_ff.idx < fieldbus_pkg::NUM_SLAVES);
    case (cur_ff.cmd)
      fieldbus_pkg::CMD_AUTO_RD, fieldbus_pkg::CMD_AUTO_WR:
        hit = (cur_ff.adp_run == fieldbus_pkg::AUTO_FIRST); // [RULE7]
      fieldbus_pkg::CMD_CFG_RD, fieldbus_pkg::CMD_CFG_WR:
        hit = (cur_ff.adp == fieldbus_pkg::CFG_FIRST + {10'h000, cur_ff.idx}); // [RULE9]
      fieldbus_pkg::CMD_BCAST_RD, fieldbus_pkg::CMD_BCAST_WR:
        hit = 1'b1; // [RULE11]
      default:
        hit = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_cur     = cur_ff;
    nxt_cur.ack = 1'b0;
    case (cur_ff.st)
      IDLE:
      begin
        if (link.req)
        begin
          nxt_cur.write   = link.write;
          nxt_cur.cmd     = link.cmd;
          nxt_cur.len     = link.len;
          nxt_cur.adp     = link.adp;
          nxt_cur.adp_run = link.adp;
          nxt_cur.ado     = link.ado[fieldbus_pkg::SLAVE_AW-1:0];
          nxt_cur.wdata   = link.wdata;
          nxt_cur.rdata   = 32'h0000_0000;
          nxt_cur.wkc     = 16'h0000;
          nxt_cur.idx     = 6'h00;
          nxt_cur.busy    = 1'b1;
          nxt_cur.st      = WALK;
        end
      end
      WALK:
      begin
        if (!live)
        begin
          nxt_cur.ack = 1'b1;
          nxt_cur.st  = ANSWER;
        end
        else
        begin
          if (hit)
          begin
            nxt_cur.wkc = cur_ff.wkc + 16'h0001; // [RULE12] [RULE13]
            if (!cur_ff.write)
            begin
              for (int k = 0; k < 4; k++)
              begin
                if (3'(k) < cur_ff.len)
                  nxt_cur.rdata[8*k +: 8] = cur_ff.rdata[8*k +: 8] |
                                            mem[cur_ff.idx][cur_ff.ado + 4'(k)]; // [RULE11]
              end
            end
          end
          nxt_cur.adp_run = cur_ff.adp_run + 16'h0001; // [RULE7]
          nxt_cur.idx     = cur_ff.idx + 6'h01;
        end
      end
      ANSWER:
      begin
        nxt_cur.busy = 1'b0;
        nxt_cur.st   = IDLE;
      end
      default: nxt_cur.st = IDLE;
    endcase
  end

  // ==========================================================================
  // State and slave register spaces
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      cur_ff    <= '0;
      cur_ff.st <= IDLE;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      for (int s = 0; s < fieldbus_pkg::NUM_SLAVES; s++)
      begin
        for (int b = 0; b < fieldbus_pkg::SLAVE_BYTES; b++)
        begin
          mem[s][b] <= 8'h00;
        end
      end
    end
    else if (live && hit && cur_ff.write)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (3'(k) < cur_ff.len)
          mem[cur_ff.idx][cur_ff.ado + 4'(k)] <= cur_ff.wdata[8*k +: 8];
      end
    end
  end

  assign busy_o     = cur_ff.busy;
  assign link.ack   = cur_ff.ack;
  assign link.rdata = cur_ff.rdata;
  assign link.wkc   = cur_ff.wkc;

endmodule

/* verif/fieldbus_slave_reg_access_checker.sv */
// Concurrent checks on the link between the register access unit and the slave ring.
`timescale 1ns/10ps
module fieldbus_slave_reg_access_checker (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic [3:0]  cmd,
  input  wire logic [15:0] adp,
  input  wire logic [15:0] ado,
  input  wire logic [2:0]  len,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  input  wire logic [15:0] wkc
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  logic is_auto;
  logic is_cfg;
  logic is_bcast;
  assign is_auto  = cmd == fieldbus_pkg::CMD_AUTO_RD || cmd == fieldbus_pkg::CMD_AUTO_WR;
  assign is_cfg   = cmd == fieldbus_pkg::CMD_CFG_RD || cmd == fieldbus_pkg::CMD_CFG_WR;
  assign is_bcast = cmd == fieldbus_pkg::CMD_BCAST_RD || cmd == fieldbus_pkg::CMD_BCAST_WR;

  // ==========================================================================
  // Request handshake
  property p_req_hold;
    req && !ack |=> req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  property p_req_drop;
    ack |=> !req && !ack;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request or ack left high after ack");
  property p_args_stable;
    req && !ack |=> $stable({write, cmd, adp, ado, len, wdata});
  endproperty
  a_args_stable: assert property (p_args_stable) else $error("request fields changed while pending");
  property p_ack_time;
    $rose(req) |-> ##[2:40] ack;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("no ack in time");

  // ==========================================================================
  // Only validated requests reach the ring; ack counts stay in range
  property p_len_ok;
    req |-> len >= fieldbus_pkg::LEN_MIN && len <= fieldbus_pkg::LEN_MAX;
  endproperty
  a_len_ok: assert property (p_len_ok) else $error("bad length on link");
  property p_cmd_ok;
    req |-> (write ? (cmd inside {4'h2, 4'h5, 4'h8}) : (cmd inside {4'h1, 4'h4, 4'h7}));
  endproperty
  a_cmd_ok: assert property (p_cmd_ok) else $error("bad command on link");
  property p_auto_adp;
    req && is_auto |-> adp == fieldbus_pkg::AUTO_FIRST || adp >= fieldbus_pkg::AUTO_LAST;
  endproperty
  a_auto_adp: assert property (p_auto_adp) else $error("bad position on link");
  property p_cfg_adp;
    req && is_cfg |-> adp >= fieldbus_pkg::CFG_FIRST && adp <= fieldbus_pkg::CFG_LAST;
  endproperty
  a_cfg_adp: assert property (p_cfg_adp) else $error("bad station on link");
  property p_wkc_single;
    ack && !is_bcast |-> wkc <= 16'h0001;
  endproperty
  a_wkc_single: assert property (p_wkc_single) else $error("addressed count above one");
  property p_wkc_bcast;
    ack && is_bcast |-> wkc <= 16'h0024;
  endproperty
  a_wkc_bcast: assert property (p_wkc_bcast) else $error("broadcast count above slave total");

  c_bcast_rd: cover property (ack && cmd == fieldbus_pkg::CMD_BCAST_RD);
  c_auto_wr: cover property (ack && cmd == fieldbus_pkg::CMD_AUTO_WR && wkc == 16'h0001);
  c_noresp: cover property (ack && wkc == 16'h0000);
endmodule

/* verif/tb_fieldbus_slave_reg_access.sv */
// Self-checking bench for the register access unit facing the slave ring.
`timescale 1ns/10ps
module tb_fieldbus_slave_reg_access;
  logic        mclk_i;
  logic        resetn_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        irq;
  logic [5:0]  cnt = 6'h24;
  logic        ring_busy;
  int          req_cycles = 0;
  logic [7:0]  mem [36][16];
  int          miscompares = 0;
  int          compares = 0;
  int          seed = 32'h9084;

  ring_link_if link_bus();
  slave_access_unit i_slave_access_unit (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .irq_o(irq), .link(link_bus));
  slave_ring_end i_slave_ring_end (.mclk_i(mclk_i), .resetn_i(resetn_i), .station_count_i(cnt),
    .busy_o(ring_busy), .link(link_bus));
  fieldbus_slave_reg_access_checker link_checker (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .req(link_bus.req), .write(link_bus.write), .cmd(link_bus.cmd), .adp(link_bus.adp), .ado(link_bus.ado),
    .len(link_bus.len), .wdata(link_bus.wdata), .ack(link_bus.ack), .rdata(link_bus.rdata), .wkc(link_bus.wkc));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
    if (link_bus.req === 1'b1) req_cycles <= req_cycles + 1;

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The master never assumes a latency: it holds the access until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================================
  // Expectations
  function automatic logic [15:0] exp_err(logic wr, logic [3:0] cmd, logic [2:0] len, logic [15:0] adp);
    logic au;
    logic cf;
    au = cmd == (wr ? 4'h2 : 4'h1);
    cf = cmd == (wr ? 4'h5 : 4'h4);
    if (!(au || cf || cmd == (wr ? 4'h8 : 4'h7))) return wr ? 16'h0f72 : 16'h0f62;
    if (len < 3'h1 || len > 3'h4) return wr ? 16'h0f71 : 16'h0f61;
    if ((au && adp != 16'h0 && adp < 16'hffdd) || (cf && (adp < 16'd1001 || adp > 16'd1036)))
      return wr ? 16'h0f70 : 16'h0f60;
    return 16'h0;
  endfunction

  // Auto-increment: each slave adds one to the position, the one seeing zero answers.
  function automatic logic hit(logic [3:0] cmd, logic [15:0] adp, int i);
    case (cmd)
      4'h1, 4'h2: return adp + 16'(i) == 16'h0;
      4'h4, 4'h5: return adp == 16'(1001 + i);
      default:    return 1'b1;
    endcase
  endfunction

  task automatic run(input logic wr, input logic [3:0] cmd, input logic [2:0] len, input logic [15:0] adp,
                     input logic [15:0] ado, input logic [31:0] d);
    logic [31:0] r;
    logic [31:0] st;
    logic [31:0] er;
    logic [15:0] ew;
    logic [15:0] code;
    logic        e;
    logic [31:0] xs;
    int          n0;
    code = exp_err(wr, cmd, len, adp);
    ew = 16'h0;
    er = 32'h0;
    for (int i = 0; i < int'(cnt); i++)
      if (code == 16'h0 && hit(cmd, adp, i))
      begin
        ew++;
        for (int k = 0; k < int'(len); k++)
          if (wr) mem[i][4'(ado + 16'(k))] = d[8*k +: 8];
          else er[8*k +: 8] |= mem[i][4'(ado + 16'(k))];
      end
    n0 = req_cycles;
    apb(1'b1, fieldbus_pkg::REG_CMD, {13'h0, len, 12'h0, cmd}, r, e);
    apb(1'b1, fieldbus_pkg::REG_ADDR, {ado, adp}, r, e);
    apb(1'b1, fieldbus_pkg::REG_WDATA, d, r, e);
    apb(1'b1, fieldbus_pkg::REG_CTRL, {30'h0, wr, 1'b1}, r, e);
    if (code == 16'h0 && cnt == 6'h24)
    begin
      apb(1'b0, fieldbus_pkg::REG_RDATA, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, ring_busy}, 32'h1);
      apb(1'b0, fieldbus_pkg::REG_WKC, 32'h0, r, e);
      chk(r, 32'h0);
    end
    do apb(1'b0, fieldbus_pkg::REG_STATUS, 32'h0, st, e); while (st[0] !== 1'b0);
    xs = {code, 12'h0, code == 16'h0 && ew == 16'h0, code != 16'h0, code == 16'h0 && ew != 16'h0, 1'b0};
    chk(st, xs);
    chk({31'h0, req_cycles != n0}, {31'h0, code == 16'h0});
    chk({31'h0, ring_busy}, 32'h0);
    apb(1'b0, fieldbus_pkg::REG_WKC, 32'h0, r, e);
    chk(r, {16'h0, ew});
    if (!wr && code == 16'h0)
    begin
      apb(1'b0, fieldbus_pkg::REG_RDATA, 32'h0, r, e);
      chk(r & (32'hffffffff >> (8 * (4 - int'(len)))), er);
    end
    apb(1'b1, fieldbus_pkg::REG_CTRL, 32'h0, r, e);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic        md;
    int          idx;
    logic [2:0]  ln;
    foreach (mem[i, k]) mem[i][k] = 8'h0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    apb(1'b0, fieldbus_pkg::REG_STATUS, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    run(1'b0, 4'h3, 3'h1, 16'h0, 16'h0, 32'h0);
    run(1'b1, 4'h1, 3'h1, 16'h0, 16'h0, 32'h0);
    run(1'b0, 4'h7, 3'h0, 16'h0, 16'h0, 32'h0);
    run(1'b1, 4'h8, 3'h5, 16'h0, 16'h0, 32'h0);
    run(1'b0, 4'h4, 3'h1, 16'd1000, 16'h0, 32'h0);
    run(1'b1, 4'h2, 3'h1, 16'hffdc, 16'h0, 32'h0);
    run(1'b1, 4'h5, 3'h2, 16'd1037, 16'h0, 32'h0);
    run(1'b0, 4'h3, 3'h0, 16'h5, 16'h0, 32'h0);
    run(1'b1, 4'h8, 3'h4, 16'h1234, 16'h0130, $random(seed));
    for (int it = 0; it < 12; it++)
    begin
      idx = (it == 0) ? 35 : (it == 1) ? 0 : int'($unsigned($random(seed)) % 36);
      md = 1'($random(seed));
      ln = 3'($unsigned($random(seed)) % 4 + 1);
      r = $random(seed);
      run(1'b1, md ? 4'h2 : 4'h5, ln, md ? 16'(-idx) : 16'(1001 + idx), r[15:0], $random(seed));
      run(1'b0, md ? 4'h4 : 4'h1, ln, md ? 16'(1001 + idx) : 16'(-idx), r[15:0], 32'h0);
    end
    apb(1'b1, fieldbus_pkg::REG_IRQ_EN, 32'h7, r, e);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, fieldbus_pkg::REG_IRQ_CLR, 32'h7, r, e);
    apb(1'b0, fieldbus_pkg::REG_IRQ_STAT, 32'h0, r, e);
    chk({31'h0, irq}, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, fieldbus_pkg::REG_IRQ_EN, 32'h1, r, e);
    // A break after the fourth slave: broadcast counts only the slaves still reached.
    // The expectation reads the count at once, so let the new count settle first.
    cnt <= 6'h04;
    @(posedge mclk_i);
    run(1'b0, 4'h7, 3'h1, 16'h4321, 16'h0130, 32'h0);
    run(1'b0, 4'h1, 3'h2, 16'hfffc, 16'h0003, 32'h0);
    apb(1'b0, fieldbus_pkg::REG_IRQ_STAT, 32'h0, r, e);
    chk(r, 32'h5);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, fieldbus_pkg::REG_IRQ_EN, 32'h2, r, e);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    print_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge mclk_i);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
